//--- dcr_readout.sv
// mode register three and calibration pattern readout path
// Operation
// - load register three on mode set; hold
// - register rewrite never touches array contents
// - select bits ignored while readout disabled
// - enable bit zero means normal array access
// - enable bit one returns calibration data
// - reads redirected to calibration register when enabled
// - pattern on prime lines or all lines
// - normal latency, full burst and chop
// - chop returns nibble chosen by bit two
// - burst bit zero is register LSB
// - other address and bank bits ignored
// - address bit twelve picks chop on-the-fly
// - pattern alternates starting with zero
// - codes 01, 10, 11 give no readout
// - bank code 011 addresses register three
// - burst starts read latency after command
`timescale 1ns/1ps
`default_nettype none
module dcr_readout #(
    parameter int DQ_W = 8,
    parameter int LAT_W = 5,
    parameter int LAT_DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire dcr_pkg::dcr_cmd_s cmd_in,
    input wire logic [LAT_W-1:0] read_latency_total,
    input wire logic all_lines_mode,
    input wire logic dll_locked,
    input wire logic [DQ_W-1:0] array_rd_data,
    output logic array_rd_sel,
    output logic array_wr_en,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic readout_enabled,
    output logic [dcr_pkg::MR_W-1:0] mode_register_three
);
    localparam int BYTES = (DQ_W + 7) / 8;
    localparam int BYTE_W = 8;

    logic [1:0] mr0_bl;
    logic is_read;
    logic is_mrs3;
    logic chop;
    logic pattern_sel;
    dcr_pkg::dcr_burst_s next_issue;
    dcr_pkg::dcr_burst_s lat_burst;
    logic [3:0] beat_left;
    logic [2:0] beat_idx;
    logic [2:0] cur_idx;
    logic [LAT_W:0] since_issue;
    logic beat_bit;
    logic [DQ_W-1:0] next_dq;

    assign is_mrs3 = cmd_in.cmd == dcr_pkg::DCR_MRS && cmd_in.ba == dcr_pkg::BA_MR3;
    assign is_read = cmd_in.cmd == dcr_pkg::DCR_READ || cmd_in.cmd == dcr_pkg::DCR_READ_AP;
    assign pattern_sel = mode_register_three[dcr_pkg::MR3_ENABLE_BIT]
        && mode_register_three[dcr_pkg::MR3_SEL_HI:dcr_pkg::MR3_SEL_LO] == dcr_pkg::SEL_PATTERN;

    // register three load; only this path writes it, array untouched
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_register_three <= dcr_pkg::MR_RESET;
        end else if (is_mrs3) begin
            mode_register_three <= dcr_pkg::MR_W'(cmd_in.addr);
        end
    end

    // burst length setting from register zero
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mr0_bl <= dcr_pkg::MR0_BL_FIXED8;
        end else if (cmd_in.cmd == dcr_pkg::DCR_MRS && cmd_in.ba == dcr_pkg::BA_MR0) begin
            mr0_bl <= cmd_in.addr[dcr_pkg::MR0_BL_HI:dcr_pkg::MR0_BL_LO];
        end
    end

    // chop decision, only bits 2 and 12 of the address matter
    always_comb begin
        chop = (mr0_bl == dcr_pkg::MR0_BL_FIXED4)
            || (mr0_bl == dcr_pkg::MR0_BL_OTF && !cmd_in.addr[dcr_pkg::A_CHOP_BIT]);
        next_issue = '0;
        next_issue.valid = is_read && pattern_sel && dll_locked;
        next_issue.beats = chop ? dcr_pkg::BEATS_CHOP : dcr_pkg::BEATS_FULL;
        next_issue.start = (chop && cmd_in.addr[dcr_pkg::A_ORDER_BIT]) ? dcr_pkg::NIBBLE_HI : 3'h0;
    end

    dcr_latency_pipe #(
        .DEPTH(LAT_DEPTH),
        .LAT_W(LAT_W)
    ) u_lat (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_burst(next_issue),
        .latency(read_latency_total),
        .out_burst(lat_burst)
    );

    // array routing when readout disabled
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            array_rd_sel <= 1'b0;
            array_wr_en <= 1'b0;
            readout_enabled <= 1'b0;
        end else begin
            readout_enabled <= mode_register_three[dcr_pkg::MR3_ENABLE_BIT];
            array_rd_sel <= is_read && !mode_register_three[dcr_pkg::MR3_ENABLE_BIT];
            array_wr_en <= cmd_in.cmd == dcr_pkg::DCR_WRITE && !mode_register_three[dcr_pkg::MR3_ENABLE_BIT];
        end
    end

    // beat sequencer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            beat_left <= '0;
            beat_idx <= '0;
        end else if (lat_burst.valid) begin
            beat_left <= lat_burst.beats - 4'h1;
            beat_idx <= lat_burst.start + 3'h1;
        end else if (beat_left != '0) begin
            beat_left <= beat_left - 4'h1;
            beat_idx <= beat_idx + 3'h1;
        end
    end

    // first beat taken straight from the delay line
    assign cur_idx = lat_burst.valid ? lat_burst.start : beat_idx;
    assign beat_bit = dcr_pkg::CAL_PATTERN[cur_idx];

    always_comb begin
        next_dq = '0;
        for (int b = 0; b < BYTES; b++) begin
            for (int i = 0; i < BYTE_W; i++) begin
                if (b * BYTE_W + i < DQ_W && (all_lines_mode || i == 0)) begin
                    next_dq[b * BYTE_W + i] = beat_bit;
                end
            end
        end
    end

    // data out: calibration beats, else array data
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else if (lat_burst.valid || beat_left != '0) begin
            dq_out <= next_dq;
            dq_oe <= 1'b1;
        end else begin
            dq_out <= array_rd_data;
            dq_oe <= 1'b0;
        end
    end

    // cycles since the last accepted calibration read, saturating
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            since_issue <= '1;
        end else if (next_issue.valid) begin
            since_issue <= {{LAT_W{1'b0}}, 1'b1};
        end else if (since_issue != '1) begin
            since_issue <= since_issue + 1'b1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    mrs_load_a: assert property (is_mrs3 |=> mode_register_three == $past(cmd_in.addr[dcr_pkg::MR_W-4:0]))
        else $error("register three not loaded");
    hold_a: assert property (!is_mrs3 |=> $stable(mode_register_three))
        else $error("register three changed without write");
    no_wr_a: assert property (mode_register_three[dcr_pkg::MR3_ENABLE_BIT] |=> !array_wr_en)
        else $error("array write while readout enabled");
    redirect_a: assert property (is_read && mode_register_three[dcr_pkg::MR3_ENABLE_BIT] |=> !array_rd_sel)
        else $error("read reached array in readout mode");
    rsvd_code_a: assert property (is_read && mode_register_three[dcr_pkg::MR3_SEL_HI:dcr_pkg::MR3_SEL_LO]
        != dcr_pkg::SEL_PATTERN |-> !next_issue.valid)
        else $error("readout for reserved code");
    first_zero_a: assert property (lat_burst.valid && lat_burst.start == 3'h0
        |=> dq_oe && dq_out[0] == 1'b0)
        else $error("pattern does not begin with zero");
    second_one_a: assert property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_CHOP
        |=> ##1 dq_out[0])
        else $error("second beat not one");
    full_len_a: assert property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_FULL |=> dq_oe [*8])
        else $error("full burst shorter than eight beats");
    lines_low_a: assert property (dq_oe && !$past(all_lines_mode) |-> dq_out[DQ_W-1:1] == '0 || DQ_W > 8)
        else $error("non prime lines not low");
    chop_end_a: assert property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_CHOP
        ##1 !lat_burst.valid [*4] |=> !dq_oe)
        else $error("chop burst longer than four beats");
    full_end_a: assert property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_FULL
        ##1 !lat_burst.valid [*8] |=> !dq_oe)
        else $error("full burst longer than eight beats");
    chop_hi_a: assert property (lat_burst.valid && lat_burst.start == dcr_pkg::NIBBLE_HI
        |=> dq_oe && !dq_out[0] ##1 dq_out[0])
        else $error("upper nibble order wrong");
    latency_a: assert property (since_issue == read_latency_total |=> dq_oe && !dq_out[0])
        else $error("burst not a read latency after command");
    array_rd_a: assert property (is_read && !mode_register_three[dcr_pkg::MR3_ENABLE_BIT] |=> array_rd_sel)
        else $error("normal read missed the array");
    array_wr_a: assert property (cmd_in.cmd == dcr_pkg::DCR_WRITE
        && !mode_register_three[dcr_pkg::MR3_ENABLE_BIT] |=> array_wr_en)
        else $error("normal write missed the array");
    enable_copy_a: assert property (readout_enabled
        == $past(mode_register_three[dcr_pkg::MR3_ENABLE_BIT]))
        else $error("enable flag does not follow register");
    all_lines_a: assert property (dq_oe && $past(all_lines_mode) |-> dq_out == {DQ_W{dq_out[0]}})
        else $error("lines differ in all lines mode");

    cov_full_c: cover property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_FULL);
    cov_chop_hi_c: cover property (lat_burst.valid && lat_burst.start == dcr_pkg::NIBBLE_HI);
    cov_enable_c: cover property (is_mrs3 ##1 pattern_sel);
    cov_chop_lo_c: cover property (lat_burst.valid && lat_burst.beats == dcr_pkg::BEATS_CHOP && lat_burst.start == 3'h0);
    cov_all_lines_c: cover property (dq_oe && all_lines_mode);
endmodule // dcr_readout
`default_nettype wire

//--- dcr_pkg.sv
// package for the calibration pattern readout block
`default_nettype none
package dcr_pkg;
    localparam int MR_W = 17;
    localparam int ADDR_W = 14;
    localparam int BA_W = 3;
    localparam logic [2:0] BA_MR3 = 3'h3;
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam int MR3_ENABLE_BIT = 2;
    localparam int MR3_SEL_HI = 1;
    localparam int MR3_SEL_LO = 0;
    localparam logic [1:0] SEL_PATTERN = 2'h0;
    localparam int A_ORDER_BIT = 2;
    localparam int A_CHOP_BIT = 12;
    localparam int MR0_BL_HI = 1;
    localparam int MR0_BL_LO = 0;
    localparam logic [1:0] MR0_BL_FIXED8 = 2'h0;
    localparam logic [1:0] MR0_BL_OTF = 2'h1;
    localparam logic [1:0] MR0_BL_FIXED4 = 2'h2;
    localparam logic [7:0] CAL_PATTERN = 8'hAA;
    localparam logic [3:0] BEATS_FULL = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;
    localparam logic [2:0] NIBBLE_HI = 3'h4;
    localparam logic [MR_W-1:0] MR_RESET = 17'h00000;

    typedef enum logic [2:0] {
        DCR_NOP, DCR_MRS, DCR_READ, DCR_READ_AP, DCR_WRITE, DCR_OTHER
    } dcr_cmd_e;

    typedef struct packed {
        dcr_cmd_e cmd;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } dcr_cmd_s;

    typedef struct packed {
        logic valid;
        logic [2:0] start;
        logic [3:0] beats;
    } dcr_burst_s;
endpackage
`default_nettype wire

//--- dcr_latency_pipe.sv
// read latency delay line for burst descriptors
`timescale 1ns/1ps
`default_nettype none
module dcr_latency_pipe #(
    parameter int DEPTH = 32,
    parameter int LAT_W = 5
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire dcr_pkg::dcr_burst_s in_burst,
    input wire logic [LAT_W-1:0] latency,
    output dcr_pkg::dcr_burst_s out_burst
);
    dcr_pkg::dcr_burst_s stage [DEPTH];
    logic [LAT_W-1:0] tap;

    // stage 0 is one cycle after issue
    always_comb begin
        tap = (latency == '0) ? '0 : LAT_W'(latency - 1'b1);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage[i] <= '0;
            end
        end else begin
            stage[0] <= in_burst;
            for (int i = 1; i < DEPTH; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    // registered read of the selected stage
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            out_burst <= '0;
        end else if (tap == '0) begin
            out_burst <= in_burst;
        end else begin
            out_burst <= stage[tap-1'b1];
        end
    end
endmodule // dcr_latency_pipe
`default_nettype wire

//--- dcr_ctrl_model.sv
// controller model issuing commands to the readout block
`timescale 1ns/1ps
`default_nettype none
module dcr_ctrl_model #(
    parameter int MOD_CYC = 12,
    parameter int RECOV_CYC = 4
) (
    input wire logic core_clk,
    output var dcr_pkg::dcr_cmd_s cmd_in
);
    initial cmd_in = '0;
    // one command for one cycle, then idle
    task automatic issue(input dcr_pkg::dcr_cmd_e c, input logic [2:0] b, input logic [13:0] a);
        @(posedge core_clk);
        cmd_in <= '{cmd: c, ba: b, addr: a};
        @(posedge core_clk);
        cmd_in <= '0;
    endtask
    // register three write with banks idle and reserved bits zero
    task automatic mrs3(input logic [2:0] low);
        repeat (RECOV_CYC) @(posedge core_clk);
        issue(dcr_pkg::DCR_MRS, dcr_pkg::BA_MR3, {11'h000, low});
        repeat (MOD_CYC) @(posedge core_clk);
    endtask
endmodule // dcr_ctrl_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the calibration readout block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    localparam int LAT = 3;
    logic core_clk, resetn, all_lines_mode, dll_locked;
    logic [4:0] read_latency_total;
    logic [7:0] array_rd_data, dq_out;
    logic array_rd_sel, array_wr_en, dq_oe, readout_enabled;
    logic [16:0] mode_register_three;
    dcr_pkg::dcr_cmd_s cmd_in;
    int checked = 0;
    int fail_count = 0;
    dcr_ctrl_model ctl (.core_clk(core_clk), .cmd_in(cmd_in));
    dcr_readout uut (.core_clk(core_clk), .resetn(resetn), .cmd_in(cmd_in),
        .read_latency_total(read_latency_total), .all_lines_mode(all_lines_mode), .dll_locked(dll_locked),
        .array_rd_data(array_rd_data), .array_rd_sel(array_rd_sel), .array_wr_en(array_wr_en), .dq_out(dq_out),
        .dq_oe(dq_oe), .readout_enabled(readout_enabled), .mode_register_three(mode_register_three));
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // calibration read, then beat by beat comparison
    task automatic burst(input dcr_pkg::dcr_cmd_e c, input logic [13:0] a, input int n);
        logic [7:0] e;
        ctl.issue(c, 3'h7, a);
        repeat (LAT - 1) @(posedge core_clk);
        for (int k = 0; k < n; k++) begin
            @(posedge core_clk);
            #1;
            e = all_lines_mode ? {8{k[0]}} : {7'h00, k[0]};
            `CHK(dq_oe, 1'h1)
            `CHK(dq_out, e)
        end
        @(posedge core_clk);
        #1;
        `CHK(dq_oe, 1'h0)
    endtask
    task automatic silent(input logic [13:0] a);
        ctl.issue(dcr_pkg::DCR_READ, 3'h0, a);
        repeat (LAT + 10) begin
            @(posedge core_clk);
            #1;
            `CHK(dq_oe, 1'h0)
        end
    endtask
    task automatic t_reset();
        `CHK(mode_register_three, 17'h00000)
        `CHK(readout_enabled, 1'h0)
        $display("reset test done");
    endtask
    task automatic t_normal();
        ctl.issue(dcr_pkg::DCR_MRS, dcr_pkg::BA_MR0, 14'h0001);
        ctl.mrs3(3'h3);
        `CHK(mode_register_three, 17'h00003)
        `CHK(readout_enabled, 1'h0)
        ctl.issue(dcr_pkg::DCR_READ, 3'h0, 14'h0000);
        #1;
        `CHK(array_rd_sel, 1'h1)
        ctl.issue(dcr_pkg::DCR_WRITE, 3'h0, 14'h0000);
        #1;
        `CHK(array_wr_en, 1'h1)
        $display("normal test done");
    endtask
    task automatic t_cal();
        ctl.mrs3(3'h4);
        `CHK(mode_register_three, 17'h00004)
        `CHK(readout_enabled, 1'h1)
        burst(dcr_pkg::DCR_READ, 14'h3FF8, 8);
        @(posedge core_clk) all_lines_mode <= 1'h1;
        burst(dcr_pkg::DCR_READ_AP, 14'h0004, 4);
        burst(dcr_pkg::DCR_READ, 14'h0000, 4);
        @(posedge core_clk) all_lines_mode <= 1'h0;
        $display("calibration test done");
    endtask
    task automatic t_refused();
        @(posedge core_clk) dll_locked <= 1'h0;
        silent(14'h1000);
        @(posedge core_clk) dll_locked <= 1'h1;
        for (int s = 5; s < 8; s++) begin
            ctl.mrs3(3'(s));
            silent(14'h1000);
        end
        ctl.mrs3(3'h0);
        `CHK(readout_enabled, 1'h0)
        ctl.issue(dcr_pkg::DCR_READ, 3'h0, 14'h0000);
        #1;
        `CHK(array_rd_sel, 1'h1)
        $display("refused test done");
    endtask
    task automatic t_fixed();
        ctl.issue(dcr_pkg::DCR_MRS, dcr_pkg::BA_MR0, 14'h0002);
        ctl.mrs3(3'h4);
        burst(dcr_pkg::DCR_READ, 14'h1000, 4);
        ctl.mrs3(3'h0);
        ctl.issue(dcr_pkg::DCR_MRS, dcr_pkg::BA_MR0, 14'h0000);
        ctl.mrs3(3'h4);
        burst(dcr_pkg::DCR_READ, 14'h0000, 8);
        ctl.mrs3(3'h0);
        $display("fixed burst test done");
    endtask
    initial begin
        resetn = 1'h0;
        all_lines_mode = 1'h0;
        dll_locked = 1'h1;
        read_latency_total = 5'(LAT);
        array_rd_data = 8'h5A;
        repeat (12) @(posedge core_clk);
        resetn <= 1'h1;
        t_reset();
        t_normal();
        t_cal();
        t_refused();
        t_fixed();
        results();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        results();
    end
endmodule // tb
`default_nettype wire
